// >>> src/wdw_top.sv
`include "wdw_map.svh"

module wdw_top
  import wdw_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        lf_osc,
  input  wire logic        hibernate,
  output logic             wdog_reset_req,
  output logic             wdog_irq
);

  function automatic wdw_reg_t wdw_decode(input logic [31:0] addr);
    case (addr)
      `WDW_ADDR_LOAD:     wdw_decode = WDW_REG_LOAD;
      `WDW_ADDR_COUNT:    wdw_decode = WDW_REG_COUNT;
      `WDW_ADDR_SETTINGS: wdw_decode = WDW_REG_SETTINGS;
      `WDW_ADDR_REFRESH:  wdw_decode = WDW_REG_REFRESH;
      `WDW_ADDR_FLAGS:    wdw_decode = WDW_REG_FLAGS;
      `WDW_ADDR_LOWER:    wdw_decode = WDW_REG_LOWER;
      default:            wdw_decode = WDW_REG_NONE;
    endcase
  endfunction

  function automatic logic [15:0] wdw_merge(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    wdw_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  function automatic logic [11:0] wdw_div_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   wdw_div_limit = `WDW_DIV_1;
      2'b01:   wdw_div_limit = `WDW_DIV_16;
      2'b10:   wdw_div_limit = `WDW_DIV_256;
      default: wdw_div_limit = `WDW_DIV_4096;
    endcase
  endfunction

  // bus side state
  logic [31:0] aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;
  logic        wr_go;
  wdw_reg_t    wr_sel;
  logic [15:0] wr_val;
  // shadow values waiting for the slow domain
  logic [15:0] load_sh_r;
  logic [15:0] lower_sh_r;
  logic [15:0] settings_sh_r;
  logic        load_busy_r;
  logic        lower_busy_r;
  logic        settings_busy_r;
  logic        refresh_busy_r;
  // active timer state
  logic [15:0] load_r;
  logic [15:0] lower_r;
  logic [15:0] settings_r;
  logic [15:0] count_r;
  logic [11:0] pre_r;
  logic        lock_r;
  logic        pending_r;
  logic        lf_prev_r;
  logic        lf_tick;
  logic        pre_tick;
  logic        counting;
  logic        zero_tmo;
  logic        window_tmo;
  logic        key_bad;
  logic        tmo_evt;
  logic [15:0] reload_val;
  logic [15:0] flags;

  assign wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_sel = wdw_decode(aw_addr_r);
  assign wr_val = wdw_merge(16'h0000, w_data_r, w_strb_r);

  // write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r     <= 1'b0;
      aw_addr_r     <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      aw_have_r     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      w_have_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WDW_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == WDW_REG_NONE) ? `WDW_RESP_DECERR : `WDW_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WDW_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `WDW_RESP_OKAY;
      case (wdw_decode(s_axi_araddr))
        WDW_REG_LOAD:     s_axi_rdata <= {16'h0000, load_r};
        WDW_REG_COUNT:    s_axi_rdata <= {16'h0000, count_r};
        WDW_REG_SETTINGS: s_axi_rdata <= {16'h0000, settings_r};
        WDW_REG_REFRESH:  s_axi_rdata <= 32'h0000_0000;
        WDW_REG_FLAGS:    s_axi_rdata <= {16'h0000, flags};
        WDW_REG_LOWER:    s_axi_rdata <= {16'h0000, lower_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `WDW_RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // slow oscillator sampled as a plain synchronous input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lf_prev_r <= 1'b0;
    else
      lf_prev_r <= lf_osc;
  end
  assign lf_tick = lf_osc && !lf_prev_r;
  // shadow writes wait for the next slow edge, as the real cells live there
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_sh_r   <= `WDW_RST_LOAD;
      load_busy_r <= 1'b0;
    end
    else if (wr_go && wr_sel == WDW_REG_LOAD)
    begin
      load_sh_r   <= wdw_merge(load_sh_r, w_data_r, w_strb_r);
      load_busy_r <= 1'b1;
    end
    else if (lf_tick)
      load_busy_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lower_sh_r   <= `WDW_RST_LOWER;
      lower_busy_r <= 1'b0;
    end
    else if (wr_go && wr_sel == WDW_REG_LOWER)
    begin
      lower_sh_r   <= wdw_merge(lower_sh_r, w_data_r, w_strb_r);
      lower_busy_r <= 1'b1;
    end
    else if (lf_tick)
      lower_busy_r <= 1'b0;
  end

  // once locked, settings writes are dropped without raising the busy flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settings_sh_r   <= `WDW_RST_SETTINGS;
      settings_busy_r <= 1'b0;
    end
    else if (wr_go && wr_sel == WDW_REG_SETTINGS && !lock_r)
    begin
      settings_sh_r   <= wdw_merge(settings_sh_r, w_data_r, w_strb_r) & `WDW_SETTINGS_MASK;
      settings_busy_r <= 1'b1;
    end
    else if (lf_tick)
      settings_busy_r <= 1'b0;
  end

  // a bad key acts at once and never sets the busy flag
  assign key_bad = wr_go && wr_sel == WDW_REG_REFRESH && wr_val != `WDW_REFRESH_KEY;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      refresh_busy_r <= 1'b0;
    else if (wr_go && wr_sel == WDW_REG_REFRESH && wr_val == `WDW_REFRESH_KEY)
      refresh_busy_r <= 1'b1;
    else if (lf_tick)
      refresh_busy_r <= 1'b0;
  end

  // active values move over on a slow edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_r     <= `WDW_RST_LOAD;
      lower_r    <= `WDW_RST_LOWER;
      settings_r <= `WDW_RST_SETTINGS;
    end
    else if (lf_tick)
    begin
      if (load_busy_r)
        load_r <= load_sh_r;
      if (lower_busy_r)
        lower_r <= lower_sh_r;
      if (settings_busy_r)
        settings_r <= settings_sh_r;
    end
  end

  // lock is sticky; only aresetn drops it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_r <= 1'b0;
    else if (lf_tick && settings_busy_r && settings_sh_r[`WDW_BIT_ENABLE])
      lock_r <= 1'b1;
  end

  assign counting = settings_r[`WDW_BIT_ENABLE] && !(hibernate && settings_r[`WDW_BIT_FREEZE]);
  assign pre_tick = lf_tick && counting && pre_r >= wdw_div_limit(settings_r[`WDW_PRE_HI:`WDW_PRE_LO]);
  assign reload_val = settings_r[`WDW_BIT_MODE] ? load_r : `WDW_WRAP_VALUE;

  // prescaler holds still while frozen, so the phase survives hibernate
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_r <= 12'h000;
    else if (lf_tick && refresh_busy_r)
      pre_r <= 12'h000;
    else if (pre_tick)
      pre_r <= 12'h000;
    else if (lf_tick && counting)
      pre_r <= pre_r + 12'h001;
  end

  assign zero_tmo   = pre_tick && !refresh_busy_r && count_r == 16'h0000;
  assign window_tmo = lf_tick && refresh_busy_r && settings_r[`WDW_BIT_WINDOW] && count_r > lower_r;
  assign tmo_evt    = zero_tmo || window_tmo || key_bad;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= `WDW_RST_COUNT;
    else if (lf_tick && refresh_busy_r)
      count_r <= reload_val;
    else if (pre_tick)
    begin
      if (count_r == 16'h0000)
        count_r <= reload_val;
      else
        count_r <= count_r - 16'h0001;
    end
  end

  // timeout action; a new timeout beats a refresh clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending_r <= 1'b0;
    else if (tmo_evt && settings_r[`WDW_BIT_ACTION])
      pending_r <= 1'b1;
    else if (lf_tick && refresh_busy_r)
      pending_r <= 1'b0;
  end

  // held until the system reset it requests comes back on aresetn
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdog_reset_req <= 1'b0;
    else if (tmo_evt && !settings_r[`WDW_BIT_ACTION])
      wdog_reset_req <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdog_irq <= 1'b0;
    else
      wdog_irq <= pending_r && settings_r[`WDW_BIT_IRQ_EN];
  end

  always_comb
  begin
    flags = 16'h0000;
    flags[`WDW_FLG_LOWER]    = lower_busy_r;
    flags[`WDW_FLG_LOCK]     = lock_r;
    flags[`WDW_FLG_SETTINGS] = settings_busy_r;
    flags[`WDW_FLG_LOAD]     = load_busy_r;
    flags[`WDW_FLG_REFRESH]  = refresh_busy_r;
    flags[`WDW_FLG_PENDING]  = pending_r;
  end

endmodule

// >>> src/wdw_map.svh
// Overview of operation
// - count register reads live 16-bit counter, ignores writes, resets to 0x1000.
// - settings register resets to 0x0069.
// - settings bit 10 gates the timeout interrupt onto the interrupt output.
// - with bit 9 set, refresh above lower bound triggers the timeout action.
// - mode bit 0 selects free-running; counter wraps around at 0x1000.
// - mode bit 1 counts from the load value down to zero.
// - prescale bits 3:2 divide the source clock by 1, 16, 256, 4096.
// - bit 1 low makes a timeout reset; high makes an interrupt.
// - freeze bit 0 low keeps counting during hibernate.
// - freeze bit 1 holds the count in hibernate, resumes without reload.
// - writing 0xCCCC to refresh reloads, restarts, clears pending interrupt; reads zero.
// - any other refresh value triggers the timeout action at once.
// - lock flag bit 4 sets once software sets the enable bit.
// - flag bits 6, 3, 2, 1 show lower bound, settings, load, refresh writes pending.
// - flag bit 0 sets on timeout interrupt and stays until cleared.
// - only a refresh write clears the pending flag, not a flag write.
// - counter and timeout run from the 32 kHz low-frequency oscillator.
// - enable bit write-protects settings until the next reset.
// - load value resets to 0x1000 and is the reload start point with mode bit 1.
`ifndef WDW_MAP_SVH
`define WDW_MAP_SVH

`define WDW_ADDR_LOAD      32'h40004000
`define WDW_ADDR_COUNT     32'h40004004
`define WDW_ADDR_SETTINGS  32'h40004008
`define WDW_ADDR_REFRESH   32'h4000400c
`define WDW_ADDR_FLAGS     32'h40004018
`define WDW_ADDR_LOWER     32'h4000401c

`define WDW_RST_LOAD       16'h1000
`define WDW_RST_COUNT      16'h1000
`define WDW_RST_SETTINGS   16'h0069
`define WDW_RST_LOWER      16'h0800
`define WDW_WRAP_VALUE     16'h1000
`define WDW_REFRESH_KEY    16'hcccc
`define WDW_SETTINGS_MASK  16'h076f

`define WDW_BIT_IRQ_EN     10
`define WDW_BIT_WINDOW     9
`define WDW_BIT_MODE       6
`define WDW_BIT_ENABLE     5
`define WDW_PRE_HI         3
`define WDW_PRE_LO         2
`define WDW_BIT_ACTION     1
`define WDW_BIT_FREEZE     0

`define WDW_FLG_LOWER      6
`define WDW_FLG_LOCK       4
`define WDW_FLG_SETTINGS   3
`define WDW_FLG_LOAD       2
`define WDW_FLG_REFRESH    1
`define WDW_FLG_PENDING    0

`define WDW_DIV_1          12'h000
`define WDW_DIV_16         12'h00f
`define WDW_DIV_256        12'h0ff
`define WDW_DIV_4096       12'hfff

`define WDW_RESP_OKAY      2'b00
`define WDW_RESP_DECERR    2'b11

`endif

// >>> src/wdw_pkg.sv
package wdw_pkg;

  typedef enum logic [2:0]
  {
    WDW_REG_LOAD     = 3'b000,
    WDW_REG_COUNT    = 3'b001,
    WDW_REG_SETTINGS = 3'b010,
    WDW_REG_REFRESH  = 3'b011,
    WDW_REG_FLAGS    = 3'b100,
    WDW_REG_LOWER    = 3'b101,
    WDW_REG_NONE     = 3'b111
  } wdw_reg_t;

endpackage

// >>> verif/wdw_properties.sv
module wdw_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        wdog_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  b_follows_w_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  b_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  b_reopens_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write channel not reopened");
  aw_closed_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  r_follows_ar_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_stable_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  r_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  ar_closed_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during data");
  reset_sticky_a: assert property (wdog_reset_req |=> wdog_reset_req)
    else $error("reset request dropped");
endmodule

// >>> verif/tb_windowed_watchdog_registers.sv
`include "wdw_map.svh"
module tb_windowed_watchdog_registers
  import wdw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [1:0] r;} wdw_row_t;
  logic        aclk = 1'b0;
  logic        aresetn, lf_osc, hibernate, wdog_reset_req, wdog_irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  int          n_mismatch, comparisons, cyc, i;
  wdw_row_t    rows [7] = '{'{`WDW_ADDR_COUNT, 32'h1000, 2'b00}, '{`WDW_ADDR_SETTINGS, 32'h0069, 2'b00},
                            '{`WDW_ADDR_REFRESH, 32'h0, 2'b00}, '{`WDW_ADDR_FLAGS, 32'h0, 2'b00},
                            '{`WDW_ADDR_LOAD, 32'h1000, 2'b00}, '{`WDW_ADDR_LOWER, 32'h0800, 2'b00},
                            '{32'h40004010, 32'h0, 2'b11}};

  wdw_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .lf_osc(lf_osc), .hibernate(hibernate), .wdog_reset_req(wdog_reset_req), .wdog_irq(wdog_irq));

  always #2.5 aclk = ~aclk;

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // entered right after an edge; ends one edge after the answer so nothing is driven twice
  // no own limit on the wait; only the hang guard ends a stuck transfer
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    axi_rd(a, rd_d, rd_r);
    chk_val(rd_d, exp);
  endtask

  // slow ticks: each high phase is one oscillator edge seen by the fast clock
  task automatic tick(input int k);
    repeat (k)
    begin
      lf_osc <= 1'b1;
      repeat (3) @(posedge aclk);
      lf_osc <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    {aresetn, lf_osc, hibernate} = '0;
    @(posedge aclk);
    do_reset();
    for (i = 0; i < 7; i++)
    begin
      axi_rd(rows[i].a, rd_d, rd_r);
      chk_val(rd_d, rows[i].d);
      chk_val({30'h0, rd_r}, {30'h0, rows[i].r});
    end
    axi_wr(32'h40004010, 32'h0);
    chk_val({30'h0, wr_r}, {30'h0, `WDW_RESP_DECERR});
    done("reset values");
    axi_wr(`WDW_ADDR_COUNT, 32'h1234);
    chk_val({30'h0, wr_r}, {30'h0, `WDW_RESP_OKAY});
    rd_chk(`WDW_ADDR_COUNT, 32'h1000);
    axi_wr(`WDW_ADDR_LOAD, 32'h4);
    rd_chk(`WDW_ADDR_FLAGS, 32'h4);
    axi_wr(`WDW_ADDR_LOWER, 32'h2);
    rd_chk(`WDW_ADDR_FLAGS, 32'h44);
    tick(1);
    rd_chk(`WDW_ADDR_FLAGS, 32'h0);
    axi_wr(`WDW_ADDR_SETTINGS, 32'h0463);
    rd_chk(`WDW_ADDR_FLAGS, 32'h8);
    tick(1);
    rd_chk(`WDW_ADDR_FLAGS, 32'h10);
    chk_bit(rd_d[1], 1'b0);
    rd_chk(`WDW_ADDR_LOWER, 32'h2);
    axi_wr(`WDW_ADDR_SETTINGS, 32'h0);
    rd_chk(`WDW_ADDR_SETTINGS, 32'h0463);
    axi_wr(`WDW_ADDR_REFRESH, 32'hcccc);
    rd_chk(`WDW_ADDR_FLAGS, 32'h12);
    tick(1);
    rd_chk(`WDW_ADDR_COUNT, 32'h4);
    tick(1);
    rd_chk(`WDW_ADDR_COUNT, 32'h3);
    hibernate <= 1'b1;
    tick(2);
    rd_chk(`WDW_ADDR_COUNT, 32'h3);
    hibernate <= 1'b0;
    tick(3);
    rd_chk(`WDW_ADDR_COUNT, 32'h0);
    tick(1);
    rd_chk(`WDW_ADDR_FLAGS, 32'h11);
    chk_bit(wdog_irq, 1'b1);
    chk_bit(wdog_reset_req, 1'b0);
    axi_wr(`WDW_ADDR_FLAGS, 32'h0);
    rd_chk(`WDW_ADDR_FLAGS, 32'h11);
    axi_wr(`WDW_ADDR_REFRESH, 32'hcccc);
    tick(1);
    rd_chk(`WDW_ADDR_FLAGS, 32'h10);
    chk_bit(wdog_irq, 1'b0);
    axi_wr(`WDW_ADDR_REFRESH, 32'h1234);
    axi_rd(`WDW_ADDR_FLAGS, rd_d, rd_r);
    chk_bit(rd_d[0], 1'b1);
    done("periodic interrupt");
    // only a reset lifts the lock, so each action mode needs its own reset
    do_reset();
    chk_bit(wdog_irq, 1'b0);
    axi_wr(`WDW_ADDR_LOAD, 32'h1);
    axi_wr(`WDW_ADDR_SETTINGS, 32'h0060);
    tick(1);
    hibernate <= 1'b1;
    axi_wr(`WDW_ADDR_REFRESH, 32'hcccc);
    tick(1);
    chk_bit(wdog_reset_req, 1'b0);
    tick(2);
    chk_bit(wdog_reset_req, 1'b1);
    done("reset action");
    hibernate <= 1'b0;
    do_reset();
    chk_bit(wdog_reset_req, 1'b0);
    axi_wr(`WDW_ADDR_SETTINGS, 32'h0262);
    tick(1);
    axi_wr(`WDW_ADDR_REFRESH, 32'hcccc);
    tick(1);
    axi_rd(`WDW_ADDR_FLAGS, rd_d, rd_r);
    chk_bit(rd_d[0], 1'b1);
    chk_bit(wdog_irq, 1'b0);
    axi_wr(`WDW_ADDR_LOWER, 32'h1000);
    tick(1);
    axi_wr(`WDW_ADDR_REFRESH, 32'hcccc);
    tick(1);
    axi_rd(`WDW_ADDR_FLAGS, rd_d, rd_r);
    chk_bit(rd_d[0], 1'b0);
    done("early refresh");
    // load differs from the wrap value so a periodic reload would show
    do_reset();
    axi_wr(`WDW_ADDR_LOAD, 32'h10);
    axi_wr(`WDW_ADDR_SETTINGS, 32'h0024);
    tick(1);
    axi_wr(`WDW_ADDR_REFRESH, 32'hcccc);
    tick(1);
    rd_chk(`WDW_ADDR_COUNT, 32'h1000);
    tick(15);
    rd_chk(`WDW_ADDR_COUNT, 32'h1000);
    tick(1);
    rd_chk(`WDW_ADDR_COUNT, 32'h0fff);
    chk_bit(wdog_reset_req, 1'b0);
    done("free running");
    tally_and_finish();
  end
endmodule

bind wdw_top wdw_checker chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .wdog_reset_req(wdog_reset_req));
